/* File: verilog/wash_seq_pkg.sv */
package wash_seq_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned TICK_CYCLES = NS_PER_S / CLK_PERIOD_NS;

  // Fixed step timing in seconds, and time unit conversion factors
  localparam logic [7:0] SPIN_CW_S = 8'h04;
  localparam logic [7:0] DRAIN_DELAY_S = 8'h03;
  localparam logic [7:0] DRAIN_TIME_S = 8'h3c;
  localparam logic [7:0] CHEM_PULSE_S = 8'h1e;
  localparam logic [7:0] FLUSH_DELAY_S = 8'h14;
  localparam logic [7:0] FLUSH_ON_S = 8'h1e;
  localparam logic [7:0] CHEM1_DEFAULT_S = 8'h1e;
  localparam logic [11:0] SEC_PER_MIN = 12'h03c;
  localparam logic [11:0] SEC_PER_QTR = 12'h00f;
  localparam logic [11:0] MIN_PER_TEN = 12'h00a;

  // Step type codes
  localparam logic [4:0] CODE_END = 5'h00;
  localparam logic [4:0] CODE_SOAK_HOT = 5'h01;
  localparam logic [4:0] CODE_FLUSH_HOT = 5'h04;
  localparam logic [4:0] CODE_WASH_HOT = 5'h07;
  localparam logic [4:0] CODE_RINSE_HOT = 5'h0a;
  localparam logic [4:0] CODE_RINSE_SPLIT = 5'h0c;
  localparam logic [4:0] CODE_FINISH = 5'h0d;
  localparam logic [4:0] CODE_EXTRACT = 5'h0e;

  // Step duration digit limits
  localparam logic [3:0] MIN_TENS_MAX = 4'h6;
  localparam logic [3:0] MIN_UNITS_MAX = 4'h9;
  localparam logic [3:0] MIN_UNITS_AT_TOP = 4'h3;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STEP = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_ELAPSED = 8'h10;
  localparam logic [7:0] REG_OUTPUTS = 8'h14;

  // CTRL fields
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_PROG = 2;
  localparam int CTRL_FINISH_SPLIT = 3;
  localparam int CTRL_RESTORE = 4;

  // STEP fields
  localparam int STEP_CODE_LSB = 0;
  localparam int STEP_TENS_LSB = 8;
  localparam int STEP_UNITS_LSB = 12;
  localparam int STEP_QTR_LSB = 16;
  localparam int STEP_CHEM_LSB = 24;

  // CONFIG fields
  localparam int CFG_CHEM1_LSB = 0;
  localparam int CFG_LANG_LSB = 8;

  localparam int NUM_CHEM = 5;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_FILL = 3'b001,
    PH_BATH = 3'b010,
    PH_SPIN_CW = 3'b011,
    PH_DRAIN_ACCEL = 3'b100,
    PH_DRAIN = 3'b101,
    PH_EXTRACT = 3'b110
  } phase_e;

endpackage : wash_seq_pkg

/* File: verilog/second_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module second_tick import wash_seq_pkg::*; #(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic tick
);

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } tick_s;

  tick_s cur;
  tick_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (cur.count >= 32'(CYCLES - 1)) begin
      next_cur.count = '0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = cur.count + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;

endmodule : second_tick
`default_nettype wire

/* File: verilog/chem_injector.sv */
`timescale 1ns/1ps
`default_nettype none
module chem_injector import wash_seq_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic fire,
  input wire logic abort,
  input wire logic [NUM_CHEM-1:0] enable,
  input wire logic [7:0] chem1_dur,
  output logic [NUM_CHEM-1:0] chem_inject,
  output logic chem_flush
);

  typedef struct packed {
    logic [NUM_CHEM-1:0][7:0] left;
    logic any_prev;
    logic flush_wait;
    logic flush_on;
    logic [7:0] flush_cnt;
  } chem_s;

  chem_s cur;
  chem_s next_cur;
  logic any_now;

  always_comb begin
    next_cur = cur;
    any_now = 1'b0;
    for (int i = 0; i < NUM_CHEM; i++) begin
      if (fire && enable[i]) begin
        next_cur.left[i] = (i == 0) ? chem1_dur : CHEM_PULSE_S;
      end else if (tick && cur.left[i] != 8'h00) begin
        next_cur.left[i] = cur.left[i] - 8'h01;
      end
      if (next_cur.left[i] != 8'h00) begin
        any_now = 1'b1;
      end
    end
    next_cur.any_prev = any_now;
    if (cur.any_prev && !any_now) begin
      next_cur.flush_wait = 1'b1;
      next_cur.flush_on = 1'b0;
      next_cur.flush_cnt = FLUSH_DELAY_S;
    end else if (tick && cur.flush_cnt != 8'h00) begin
      next_cur.flush_cnt = cur.flush_cnt - 8'h01;
    end else if (cur.flush_cnt == 8'h00 && cur.flush_wait) begin
      next_cur.flush_wait = 1'b0;
      next_cur.flush_on = 1'b1;
      next_cur.flush_cnt = FLUSH_ON_S;
    end else if (cur.flush_cnt == 8'h00) begin
      next_cur.flush_on = 1'b0;
    end
    if (abort) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CHEM; i++) begin
      chem_inject[i] = cur.left[i] != 8'h00;
    end
  end

  assign chem_flush = cur.flush_on;

endmodule : chem_injector
`default_nettype wire

/* File: verilog/wash_step_sequencer.sv */
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wash_step_sequencer import wash_seq_pkg::*; #(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic level_high_reached,
  input wire logic level_low_reached,
  input wire logic drain_speed_reached,
  output logic hot_valve,
  output logic cold_valve,
  output logic level_select_high,
  output logic motor_reverse,
  output logic motor_cw_wash,
  output logic motor_drain_speed,
  output logic motor_extract,
  output logic drain_open,
  output logic [NUM_CHEM-1:0] chem_inject,
  output logic chem_flush
);

  typedef struct packed {
    phase_e phase;
    logic [4:0] code;
    logic [11:0] target;
    logic [11:0] elapsed;
    logic [7:0] sec_cnt;
    logic [NUM_CHEM-1:0] chem_en;
    logic [31:0] step_reg;
    logic prog_mode;
    logic finish_split;
    logic [7:0] chem1_dur;
    logic [2:0] language;
    logic invalid;
    logic step_done;
    logic formula_end;
    logic chem_fire;
    logic chem_abort;
    logic [31:0] rdata;
  } seq_s;

  seq_s cur;
  seq_s next_cur;
  logic tick;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [4:0] new_code;
  logic [3:0] new_tens;
  logic [3:0] new_units;
  logic [1:0] new_qtr;
  logic code_ok;
  logic time_ok;
  logic high_level;
  logic level_ok;
  logic want_hot;
  logic want_cold;
  logic [11:0] new_seconds;
  logic [31:0] out_bits;
  logic [31:0] read_mux;

  second_tick #(
    .CYCLES(TICK_CYCLES_P)
  ) u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(tick)
  );

  chem_injector u_chem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(tick),
    .fire(cur.chem_fire),
    .abort(cur.chem_abort),
    .enable(cur.chem_en),
    .chem1_dur(cur.chem1_dur),
    .chem_inject(chem_inject),
    .chem_flush(chem_flush)
  );

  // Step register fields awaiting start
  always_comb begin
    new_code = cur.step_reg[STEP_CODE_LSB +: 5];
    new_tens = cur.step_reg[STEP_TENS_LSB +: 4];
    new_units = cur.step_reg[STEP_UNITS_LSB +: 4];
    new_qtr = cur.step_reg[STEP_QTR_LSB +: 2];
    code_ok = new_code <= CODE_EXTRACT;
    time_ok = (new_tens < MIN_TENS_MAX && new_units <= MIN_UNITS_MAX) ||
      (new_tens == MIN_TENS_MAX && new_units <= MIN_UNITS_AT_TOP);
    new_seconds = (12'(new_tens) * MIN_PER_TEN + 12'(new_units)) *
      SEC_PER_MIN + 12'(new_qtr) * SEC_PER_QTR;
  end

  // Step type decode for running step
  always_comb begin
    high_level = cur.code < CODE_WASH_HOT ||
      (cur.code >= CODE_RINSE_HOT && cur.code <= CODE_RINSE_SPLIT);
    want_hot = 1'b0;
    want_cold = 1'b0;
    case (cur.code)
      5'h01, 5'h04, 5'h07, 5'h0a: begin
        want_hot = 1'b1;
      end
      5'h02, 5'h05, 5'h08, 5'h0b: begin
        want_cold = 1'b1;
      end
      5'h03, 5'h06, 5'h09, 5'h0c: begin
        want_hot = 1'b1;
        want_cold = 1'b1;
      end
      CODE_FINISH: begin
        want_hot = cur.finish_split;
        want_cold = 1'b1;
      end
      default: begin
        want_hot = 1'b0;
        want_cold = 1'b0;
      end
    endcase
    level_ok = high_level ? level_high_reached : level_low_reached;
  end

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign mapped = paddr == REG_CTRL || paddr == REG_STEP ||
    paddr == REG_CONFIG || paddr == REG_STATUS ||
    paddr == REG_ELAPSED || paddr == REG_OUTPUTS;

  always_comb begin
    out_bits = '0;
    out_bits[0] = hot_valve;
    out_bits[1] = cold_valve;
    out_bits[2] = level_select_high;
    out_bits[3] = motor_reverse;
    out_bits[4] = motor_cw_wash;
    out_bits[5] = motor_drain_speed;
    out_bits[6] = motor_extract;
    out_bits[7] = drain_open;
    out_bits[8 +: NUM_CHEM] = chem_inject;
    out_bits[13] = chem_flush;
  end

  always_comb begin
    read_mux = '0;
    case (paddr)
      REG_CTRL: begin
        read_mux[CTRL_PROG] = cur.prog_mode;
        read_mux[CTRL_FINISH_SPLIT] = cur.finish_split;
      end
      REG_STEP: begin
        read_mux = cur.step_reg;
      end
      REG_CONFIG: begin
        read_mux[CFG_CHEM1_LSB +: 8] = cur.chem1_dur;
        read_mux[CFG_LANG_LSB +: 3] = cur.language;
      end
      REG_STATUS: begin
        read_mux[2:0] = cur.phase;
        read_mux[4] = cur.invalid;
        read_mux[5] = cur.step_done;
        read_mux[6] = cur.formula_end;
        read_mux[12:8] = cur.code;
      end
      REG_ELAPSED: begin
        read_mux[11:0] = cur.elapsed;
        read_mux[27:16] = cur.target;
      end
      REG_OUTPUTS: begin
        read_mux = out_bits;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  always_comb begin
    next_cur = cur;
    next_cur.chem_fire = 1'b0;
    next_cur.chem_abort = 1'b0;
    if (setup && !pwrite) begin
      next_cur.rdata = read_mux;
    end
    // Sequencer
    case (cur.phase)
      PH_IDLE: begin
        next_cur.elapsed = '0;
      end
      PH_FILL: begin
        if (level_ok) begin
          next_cur.phase = PH_BATH;
          next_cur.elapsed = '0;
          next_cur.chem_fire = 1'b1;
        end
      end
      PH_BATH: begin
        if (cur.elapsed == cur.target) begin
          next_cur.phase = PH_SPIN_CW;
          next_cur.sec_cnt = SPIN_CW_S;
        end else if (tick) begin
          next_cur.elapsed = cur.elapsed + 12'h001;
        end
      end
      PH_SPIN_CW: begin
        if (cur.sec_cnt == 8'h00) begin
          next_cur.phase = PH_DRAIN_ACCEL;
          next_cur.sec_cnt = DRAIN_DELAY_S;
        end else if (tick) begin
          next_cur.sec_cnt = cur.sec_cnt - 8'h01;
        end
      end
      PH_DRAIN_ACCEL: begin
        if (cur.sec_cnt == 8'h00) begin
          next_cur.phase = PH_DRAIN;
          next_cur.sec_cnt = DRAIN_TIME_S;
        end else if (tick && drain_speed_reached) begin
          next_cur.sec_cnt = cur.sec_cnt - 8'h01;
        end
      end
      PH_DRAIN: begin
        if (cur.sec_cnt == 8'h00) begin
          next_cur.phase = PH_IDLE;
          next_cur.step_done = 1'b1;
        end else if (tick) begin
          next_cur.sec_cnt = cur.sec_cnt - 8'h01;
        end
      end
      PH_EXTRACT: begin
        if (cur.elapsed == cur.target) begin
          next_cur.phase = PH_IDLE;
          next_cur.step_done = 1'b1;
        end else if (tick) begin
          next_cur.elapsed = cur.elapsed + 12'h001;
        end
      end
      default: begin
        next_cur.phase = PH_IDLE;
      end
    endcase
    // Register writes
    if (wr) begin
      case (paddr)
        REG_CTRL: begin
          next_cur.prog_mode = pwdata[CTRL_PROG];
          next_cur.finish_split = pwdata[CTRL_FINISH_SPLIT];
          if (pwdata[CTRL_RESTORE] && cur.prog_mode) begin
            next_cur.chem1_dur = CHEM1_DEFAULT_S;
          end
          if (pwdata[CTRL_ABORT]) begin
            next_cur.phase = PH_IDLE;
            next_cur.chem_abort = 1'b1;
          end else if (pwdata[CTRL_START] && cur.phase == PH_IDLE) begin
            next_cur.step_done = 1'b0;
            next_cur.formula_end = 1'b0;
            next_cur.invalid = 1'b0;
            if (!code_ok || !time_ok) begin
              next_cur.invalid = 1'b1;
            end else begin
              next_cur.code = new_code;
              next_cur.target = new_seconds;
              next_cur.elapsed = '0;
              next_cur.chem_en = '0;
              if (new_code == CODE_END) begin
                next_cur.formula_end = 1'b1;
              end else if (new_code == CODE_EXTRACT) begin
                next_cur.phase = PH_EXTRACT;
              end else begin
                next_cur.phase = PH_FILL;
                next_cur.chem_en =
                  cur.step_reg[STEP_CHEM_LSB +: NUM_CHEM];
              end
            end
          end
        end
        REG_STEP: begin
          next_cur.step_reg = pwdata;
        end
        REG_CONFIG: begin
          if (cur.prog_mode) begin
            next_cur.chem1_dur = pwdata[CFG_CHEM1_LSB +: 8];
            next_cur.language = pwdata[CFG_LANG_LSB +: 3];
          end
        end
        default: begin
          next_cur.rdata = cur.rdata;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur <= '0;
      cur.chem1_dur <= CHEM1_DEFAULT_S;
    end else begin
      cur <= next_cur;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = cur.rdata;

  // Outputs decoded from registered phase and step code
  assign hot_valve = cur.phase == PH_FILL && want_hot;
  assign cold_valve = cur.phase == PH_FILL && want_cold;
  assign level_select_high = cur.phase == PH_FILL && high_level;
  assign motor_reverse = (cur.phase == PH_FILL || cur.phase == PH_BATH) &&
    cur.code >= CODE_FLUSH_HOT;
  assign motor_cw_wash = cur.phase == PH_SPIN_CW;
  assign motor_drain_speed = cur.phase == PH_DRAIN_ACCEL ||
    cur.phase == PH_DRAIN;
  assign motor_extract = cur.phase == PH_EXTRACT;
  assign drain_open = cur.phase == PH_DRAIN || cur.phase == PH_EXTRACT;

endmodule : wash_step_sequencer
`default_nettype wire

/* File: testbench/wash_seq_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module wash_seq_asserts import wash_seq_pkg::*; #(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic level_high_reached,
  input wire logic level_low_reached,
  input wire logic hot_valve,
  input wire logic cold_valve,
  input wire logic level_select_high,
  input wire logic motor_cw_wash,
  input wire logic motor_drain_speed,
  input wire logic motor_extract,
  input wire logic drain_open,
  input wire logic [NUM_CHEM-1:0] chem_inject,
  input wire logic chem_flush
);
  localparam int T = TICK_CYCLES_P;
  int run2, cw_run, gap, fl_run;
  logic fill_on;
  assign fill_on = hot_valve || cold_valve;
  // Run lengths of the timed outputs and of the gap with no chemical, in cycles
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      run2 <= 0;
      cw_run <= 0;
      gap <= 0;
      fl_run <= 0;
    end else begin
      run2 <= chem_inject[1] ? run2 + 1 : 0;
      cw_run <= motor_cw_wash ? cw_run + 1 : 0;
      gap <= (|chem_inject) ? 0 : gap + 1;
      fl_run <= chem_flush ? fl_run + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence level_seen_s;
    $past(level_high_reached || level_low_reached);
  endsequence
  sequence flush_start_s;
    $rose(chem_flush);
  endsequence
  fill_stop_a: assert property (
    fill_on && (level_select_high ? level_high_reached : level_low_reached)
    |-> ##[1:3] !fill_on) else $error("fill ran past level");
  valve_fill_a: assert property (
    fill_on |-> !motor_extract && !drain_open && !motor_cw_wash)
    else $error("valve open outside fill");
  chem_level_a: assert property (
    $rose(|chem_inject) |-> level_seen_s) else $error("chemical before level");
  chem_extract_a: assert property (
    motor_extract |-> chem_inject == '0) else $error("chemical in extract");
  pulse_len_a: assert property (
    $fell(chem_inject[1]) |-> run2 >= 29 * T && run2 <= 31 * T)
    else $error("chemical pulse length");
  flush_gap_a: assert property (
    flush_start_s |-> chem_inject == '0 && gap >= 19 * T && gap <= 21 * T)
    else $error("flush delay");
  flush_len_a: assert property (
    $fell(chem_flush) |-> fl_run >= 29 * T && fl_run <= 31 * T)
    else $error("flush length");
  cw_drain_a: assert property (
    $fell(motor_cw_wash) |-> motor_drain_speed && cw_run >= 3 * T
    && cw_run <= 5 * T) else $error("clockwise spin to drain");
  drain_speed_a: assert property (
    drain_open |-> motor_drain_speed || motor_extract)
    else $error("drain open at low speed");
endmodule : wash_seq_asserts
bind wash_step_sequencer wash_seq_asserts #(
  .TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (.clk_sys, .reset_n,
  .level_high_reached, .level_low_reached, .hot_valve, .cold_valve,
  .level_select_high, .motor_cw_wash, .motor_drain_speed, .motor_extract,
  .drain_open, .chem_inject, .chem_flush);
`default_nettype wire

/* File: testbench/wash_plant_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wash_plant_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic hot_valve,
  input wire logic cold_valve,
  input wire logic drain_open,
  input wire logic motor_drain_speed,
  output logic level_high_reached,
  output logic level_low_reached,
  output logic drain_speed_reached
);
  int water, spin;
  logic half;
  // Tank rises while a valve is open, half rate when slow
  always_ff @(posedge clk_sys) begin
    half <= !half && reset_n;
    if (!reset_n || drain_open) begin
      water <= 0;
    end else if (fill_gate()) begin
      water <= water + 1;
    end
    spin <= (motor_drain_speed && reset_n) ? spin + 1 : 0;
  end
  function automatic logic fill_gate();
    return (hot_valve || cold_valve) && (!slow || half);
  endfunction : fill_gate
  assign level_low_reached = water >= 20;
  assign level_high_reached = water >= 40;
  assign drain_speed_reached = spin >= 15;
endmodule : wash_plant_model
`default_nettype wire

/* File: testbench/wash_step_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wash_step_sequencer_tb import wash_seq_pkg::*; ;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic slow = 0, last_err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, level_high_reached, level_low_reached;
  logic drain_speed_reached, hot_valve, cold_valve, level_select_high;
  logic motor_reverse, motor_cw_wash, motor_drain_speed, motor_extract;
  logic drain_open, chem_flush;
  logic [NUM_CHEM-1:0] chem_inject;
  int n_errors = 0, checks_done = 0;
  wash_step_sequencer #(.TICK_CYCLES_P(10)) dut_u (.clk_sys, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .level_high_reached, .level_low_reached, .drain_speed_reached,
    .hot_valve, .cold_valve, .level_select_high, .motor_reverse,
    .motor_cw_wash, .motor_drain_speed, .motor_extract, .drain_open,
    .chem_inject, .chem_flush);
  wash_plant_model plant_u (.clk_sys, .reset_n, .slow, .hot_valve,
    .cold_valve, .drain_open, .motor_drain_speed, .level_high_reached,
    .level_low_reached, .drain_speed_reached);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1) begin
      @(posedge clk_sys);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wait_idle();
    int n;
    n = 0;
    apb(0, REG_STATUS, 0);
    while (q[2:0] !== 3'h0 && n < 1500) begin
      n++;
      apb(0, REG_STATUS, 0);
    end
    chk({31'h0, n < 1500}, 32'h1, "step hung");
  endtask : wait_idle
  task automatic t_reset();
    apb(0, REG_STATUS, 0);
    chk(q, 32'h0, "status at reset");
    apb(0, REG_OUTPUTS, 0);
    chk(q, 32'h0, "outputs at reset");
    apb(0, REG_CONFIG, 0);
    chk(q, 32'h1e, "config at reset");
    apb(0, 8'h20, 0);
    chk({q[30:0], last_err}, 32'h1, "unmapped read");
  endtask : t_reset
  task automatic t_codes();
    logic [4:0] c;
    logic sp;
    logic [3:0] e;
    apb(1, REG_STEP, 32'h0);
    apb(1, REG_CTRL, 32'h1);
    apb(0, REG_STATUS, 0);
    chk(q & 32'h47, 32'h40, "end code");
    for (int i = 1; i <= 14; i++) begin
      c = (i > 13) ? 5'h0d : 5'(i);
      sp = (i == 14);
      e[3] = (c < 13) ? ((c - 1) % 3 != 1) : sp;
      e[2] = (c < 13) ? ((c - 1) % 3 != 0) : 1'h1;
      e[1] = (c <= 6) || (c >= 10 && c <= 12);
      e[0] = c >= 5'h04;
      apb(1, REG_CTRL, {28'h0, sp, 3'h0});
      apb(1, REG_STEP, {27'h0, c});
      apb(1, REG_CTRL, {28'h0, sp, 3'h1});
      chk({hot_valve, cold_valve, level_select_high, motor_reverse}, e, "fill");
      wait_idle();
    end
  endtask : t_codes
  task automatic t_limits();
    logic [31:0] bad [5] = '{32'h0f, 32'h1f, 32'h701, 32'ha001, 32'h4601};
    foreach (bad[i]) begin
      apb(1, REG_STEP, bad[i]);
      apb(1, REG_CTRL, 32'h1);
      apb(0, REG_STATUS, 0);
      chk(q & 32'h17, 32'h10, "refused");
    end
    apb(1, REG_STEP, 32'h33601);
    apb(1, REG_CTRL, 32'h1);
    apb(0, REG_STATUS, 0);
    chk(q & 32'h17, 32'h1, "top time");
    apb(0, REG_ELAPSED, 0);
    chk(q[27:16], 12'hef1, "top seconds");
    apb(1, REG_CTRL, 32'h2);
    wait_idle();
  endtask : t_limits
  task automatic t_extract();
    int n;
    // Extract began four edges before the loop
    n = 4;
    apb(1, REG_STEP, 32'h1f01000e);
    apb(1, REG_CTRL, 32'h1);
    chk({motor_extract, drain_open, chem_inject}, 32'h60, "extract");
    apb(0, REG_ELAPSED, 0);
    chk(q[27:16], 12'h00f, "quarter");
    while (motor_extract === 1'h1 && n < 400) begin
      n++;
      @(posedge clk_sys);
    end
    chk({31'h0, n >= 140 && n <= 160}, 32'h1, "extract time");
    wait_idle();
  endtask : t_extract
  task automatic t_config();
    apb(1, REG_CTRL, 32'h4);
    apb(1, REG_CONFIG, 32'h305);
    apb(1, REG_CTRL, 32'h0);
    apb(1, REG_CONFIG, 32'h109);
    apb(0, REG_CONFIG, 0);
    chk(q[10:0], 11'h305, "config lock");
  endtask : t_config
  task automatic t_chem(input logic [4:0] c, input logic [4:0] en);
    int n;
    n = 0;
    apb(1, REG_STEP, {3'h0, en, 19'h0, c});
    apb(1, REG_CTRL, 32'h1);
    while (chem_inject === 5'h00 && n < 300) begin
      n++;
      @(posedge clk_sys);
    end
    chk(chem_inject, en, "together");
    chk({motor_cw_wash, motor_drain_speed, drain_open}, 4, "cw");
    repeat (70) @(posedge clk_sys);
    chk(chem_inject, en & 5'h1e, "chem1 short");
    while (chem_flush !== 1'h1 && n < 800) begin
      n++;
      @(posedge clk_sys);
    end
    chk({chem_flush, chem_inject}, 32'h20, "flush");
    while (chem_flush === 1'h1 && n < 1500) begin
      n++;
      @(posedge clk_sys);
    end
    wait_idle();
  endtask : t_chem
  task automatic t_restore();
    apb(1, REG_CTRL, 32'h4);
    apb(1, REG_CTRL, 32'h14);
    apb(0, REG_CONFIG, 0);
    chk(q[7:0], 8'h1e, "restore");
    apb(1, REG_CTRL, 32'h0);
  endtask : t_restore
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(posedge clk_sys);
    t_reset();
    t_codes();
    t_limits();
    t_extract();
    t_config();
    t_chem(5'h0a, 5'h1f);
    slow <= 1'h1;
    t_chem(5'h0d, 5'h0a);
    t_restore();
    conclude();
  end
endmodule : wash_step_sequencer_tb
`default_nettype wire
